// >>> hdl/qdu_core.sv
// Top of the quad DAC digital side: serial slave, update logic, busy pin
`timescale 1ns/100ps
`include "qdu_map.svh"
module qdu_core #(
	parameter int NV_CYCLES = `QDU_NV_CYCLES // Programming busy time in cycles
) (
	input wire logic core_clk_in, // Core clock, 20 MHz
	input wire logic resetn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable, freezes state when low
	input wire logic scl_in, // Serial clock level from bus
	input wire logic sda_in, // Serial data level from bus
	output logic sda_out, // Serial data drive value, always low
	output logic sda_oe_n_out, // Low while pulling the data line low
	input wire logic load_strobe_n_in, // Load strobe pin, active low
	input wire logic [`QDU_CODE_W*4-1:0] nv_code_in, // Stored codes, A in low bits
	input wire logic nv_reload_in, // Pulse: general call style reload
	output logic nv_program_ready_n_busy_oe_n_out, // Low while pulling busy low
	output logic [`QDU_CODE_W*4-1:0] dac_out, // Output registers, A in low bits
	output logic [`QDU_CODE_W*4-1:0] input_reg_out // Input registers, A in low bits
);
	// ****************************************
	// Pin synchronisers and edges
	// ****************************************
	logic scl_s, scl_rise, scl_fall;
	logic sda_s, sda_rise, sda_fall;
	logic ld_s, ld_fall;
	qdu_edge_sync u_scl (.clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.sig_in(scl_in), .level_out(scl_s), .fall_out(scl_fall), .rise_out(scl_rise));
	qdu_edge_sync u_sda (.clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.sig_in(sda_in), .level_out(sda_s), .fall_out(sda_fall), .rise_out(sda_rise));
	qdu_edge_sync u_ld (.clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.sig_in(load_strobe_n_in), .level_out(ld_s), .fall_out(ld_fall), .rise_out());
	// Start and stop are data moves with clock high; legal bits move only while low
	logic start_c, stop_c;
	assign start_c = scl_s & sda_fall & ~scl_rise;
	assign stop_c = scl_s & sda_rise & ~scl_rise;
	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic [3:0] chan_onehot(input qdu_pkg::qdu_chan_t sel);
		chan_onehot = 4'h1 << sel;
	endfunction
	// Address write shares the single write code; bits 4:3 both low set it apart
	function automatic logic addr_wr(input logic [7:0] b);
		addr_wr = (b[`QDU_CMD_HI:`QDU_CMD_LO] == `QDU_CMD_ADDR) && (b[4:3] == 2'b00);
	endfunction
	// ****************************************
	// Serial slave state
	// ****************************************
	qdu_pkg::qdu_state_e state_r, ret_r;
	logic [7:0] shift_r;
	logic [3:0] bit_r;
	logic [7:0] byte0_r;
	logic [7:0] byte1_r;
	logic ack_r; // Pulling data low for acknowledge
	logic last_ack_r; // One-cycle pulse: final data byte acknowledged
	logic gc_r; // Frame addressed by general call
	logic [2:0] addr_r;
	logic addr_sel_r; // Strobe was low at address-op frame start
	logic nv_start_r; // Pulse: start nonvolatile programming
	logic gc_reset_r; // Pulse: general call reset received
	logic [7:0] full_byte;
	assign full_byte = {shift_r[6:0], sda_s};
	// Bit counter and shifter; data taken only on clock rise
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			shift_r <= 8'h00;
			bit_r <= 4'h0;
		end else if (ce_in) begin
			if (start_c || stop_c) begin
				bit_r <= 4'h0;
			end else if (scl_rise && state_r != qdu_pkg::QDU_ACK) begin
				shift_r <= full_byte;
				bit_r <= bit_r + 4'h1;
			end else if (scl_fall && bit_r == 4'h8) begin
				bit_r <= 4'h0;
			end
		end
	end
	// Frame sequencer; acknowledge driven from clock fall to clock fall
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= qdu_pkg::QDU_IDLE;
			ret_r <= qdu_pkg::QDU_IDLE;
			ack_r <= 1'b0;
			last_ack_r <= 1'b0;
			gc_r <= 1'b0;
			byte0_r <= 8'h00;
			byte1_r <= 8'h00;
			addr_sel_r <= 1'b0;
			nv_start_r <= 1'b0;
			gc_reset_r <= 1'b0;
			addr_r <= `QDU_ADDR_RST;
		end else if (ce_in) begin
			last_ack_r <= 1'b0;
			nv_start_r <= 1'b0;
			gc_reset_r <= 1'b0;
			if (start_c) begin
				state_r <= qdu_pkg::QDU_ADDR;
				ack_r <= 1'b0;
				addr_sel_r <= ~ld_s;
			end else if (stop_c) begin
				state_r <= qdu_pkg::QDU_IDLE;
				ack_r <= 1'b0;
			end else begin
				case (state_r)
					qdu_pkg::QDU_ADDR: begin
						if (scl_fall && bit_r == 4'h8) begin
							if (shift_r[7:1] == {`QDU_SLV_FIXED, addr_r} && !shift_r[0]) begin
								gc_r <= 1'b0;
								ack_r <= 1'b1;
								state_r <= qdu_pkg::QDU_ACK;
								ret_r <= qdu_pkg::QDU_B0;
							end else if (shift_r == {`QDU_GC_ADDR, 1'b0}) begin
								gc_r <= 1'b1;
								ack_r <= 1'b1;
								state_r <= qdu_pkg::QDU_ACK;
								ret_r <= qdu_pkg::QDU_B0;
							end else begin
								// Reads are not served here; no response at all
								state_r <= qdu_pkg::QDU_SKIP;
							end
						end
					end
					qdu_pkg::QDU_B0: begin
						if (scl_fall && bit_r == 4'h8) begin
							byte0_r <= shift_r;
							ack_r <= 1'b1;
							state_r <= qdu_pkg::QDU_ACK;
							ret_r <= qdu_pkg::QDU_B1;
							if (gc_r) begin
								ret_r <= qdu_pkg::QDU_SKIP;
								gc_reset_r <= (shift_r == `QDU_GC_RESET);
							end else if (addr_wr(shift_r) && !addr_sel_r) begin
								// Address write needs the strobe low at frame start
								ret_r <= qdu_pkg::QDU_SKIP;
							end
						end
					end
					qdu_pkg::QDU_B1: begin
						if (scl_fall && bit_r == 4'h8) begin
							byte1_r <= shift_r;
							ack_r <= 1'b1;
							state_r <= qdu_pkg::QDU_ACK;
							ret_r <= qdu_pkg::QDU_B2;
						end
					end
					qdu_pkg::QDU_B2: begin
						if (scl_fall && bit_r == 4'h8) begin
							ack_r <= 1'b1;
							state_r <= qdu_pkg::QDU_ACK;
							ret_r <= qdu_pkg::QDU_B0;
							last_ack_r <= 1'b1;
							nv_start_r <= byte0_r[4];
						end
					end
					qdu_pkg::QDU_ACK: begin
						if (scl_fall) begin
							ack_r <= 1'b0;
							state_r <= ret_r;
						end
					end
					qdu_pkg::QDU_SKIP: begin
						ack_r <= 1'b0;
					end
					default: begin
						state_r <= qdu_pkg::QDU_IDLE;
						ack_r <= 1'b0;
					end
				endcase
			end
		end
	end
	// Device never drives the clock; only data is pulled low
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sda_out <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			sda_oe_n_out <= ~ack_r;
		end
	end
	// ****************************************
	// Input and output registers
	// ****************************************
	qdu_pkg::qdu_chan_t sel_c;
	logic [3:0] hit_c;
	qdu_pkg::qdu_code_t code_c;
	logic reload_c;
	logic nv_reload_d_r;
	assign sel_c = byte0_r[`QDU_SEL_HI:`QDU_SEL_LO];
	assign hit_c = chan_onehot(sel_c);
	assign code_c = {byte1_r[`QDU_B1_CODE_HI:0], shift_r};
	// Reset reload: one cycle after release, on general call reset or on the nv_reload_in pulse
	assign reload_c = nv_reload_d_r | gc_reset_r | nv_reload_in;
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nv_reload_d_r <= 1'b1;
		end else if (ce_in) begin
			nv_reload_d_r <= 1'b0;
		end
	end
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			input_reg_out <= '0;
			dac_out <= '0;
		end else if (ce_in) begin
			if (reload_c) begin
				input_reg_out <= nv_code_in;
				dac_out <= nv_code_in;
			end else begin
				if (last_ack_r && byte0_r[`QDU_CMD_HI:`QDU_CMD_LO] == `QDU_CMD_SINGLE
						&& !addr_wr(byte0_r)) begin
					for (int i = 0; i < 4; i++) begin
						if (hit_c[i]) begin
							input_reg_out[i*`QDU_CODE_W +: `QDU_CODE_W] <= code_c;
							// Strobe low or update bit low moves the new code straight out
							if (!ld_s || !byte0_r[`QDU_UPD_POS]) begin
								dac_out[i*`QDU_CODE_W +: `QDU_CODE_W] <= code_c;
							end
						end
					end
				end
				if (ld_fall) begin
					dac_out <= input_reg_out;
				end
			end
		end
	end
	// ****************************************
	// Nonvolatile programming busy timer
	// ****************************************
	logic [$clog2(NV_CYCLES+1)-1:0] nv_cnt_r;
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nv_cnt_r <= '0;
			nv_program_ready_n_busy_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			if (nv_start_r && nv_cnt_r == '0) begin
				nv_cnt_r <= ($clog2(NV_CYCLES+1))'(NV_CYCLES);
				nv_program_ready_n_busy_oe_n_out <= 1'b0;
			end else if (nv_cnt_r > 1) begin
				nv_cnt_r <= nv_cnt_r - 1'b1;
			end else begin
				nv_cnt_r <= '0;
				nv_program_ready_n_busy_oe_n_out <= 1'b1;
			end
		end
	end
endmodule

// >>> hdl/qdu_map.svh
// Constants for the quad DAC update and bus pin block
`ifndef QDU_MAP_SVH
`define QDU_MAP_SVH
// ****************************************
// Field positions and widths
// ****************************************
`define QDU_CODE_W 12
`define QDU_CHAN_W 2
`define QDU_CMD_W 3
// Single channel write byte 0: cmd[7:5] sel[2:1] update bit[0]
`define QDU_CMD_HI 7
`define QDU_CMD_LO 5
`define QDU_SEL_HI 2
`define QDU_SEL_LO 1
`define QDU_UPD_POS 0
// Single channel write command code
`define QDU_CMD_SINGLE 3'h3
// Address write command code (accepted in full only with load strobe low)
`define QDU_CMD_ADDR 3'h3
// Data byte 1 code bits
`define QDU_B1_CODE_HI 3
// ****************************************
// Reset values
// ****************************************
`define QDU_ADDR_RST 3'h0
`define QDU_SLV_FIXED 4'hC
`define QDU_CODE_RST 12'h000
`define QDU_GC_ADDR 7'h00
`define QDU_GC_RESET 8'h06
// ****************************************
// Timing
// ****************************************
`define QDU_CLK_NS 50
// Nonvolatile write busy time, ms as printed (typical)
`define QDU_NV_WRITE_MS 25
`define QDU_NV_CYCLES ((`QDU_NV_WRITE_MS * 1000000) / `QDU_CLK_NS)
`endif

// >>> hdl/qdu_pkg.sv
// Types for the quad DAC update and bus pin block
package qdu_pkg;
	typedef logic [11:0] qdu_code_t;
	typedef logic [1:0] qdu_chan_t;
	typedef enum logic [2:0] {
		QDU_IDLE = 3'b000,
		QDU_ADDR = 3'b001,
		QDU_B0 = 3'b010,
		QDU_B1 = 3'b011,
		QDU_B2 = 3'b100,
		QDU_ACK = 3'b101,
		QDU_SKIP = 3'b110
	} qdu_state_e;
endpackage

// >>> hdl/qdu_edge_sync.sv
// Two-flop synchroniser with falling and rising edge pulses
`timescale 1ns/100ps
module qdu_edge_sync (
	input wire logic clk_in, // Core clock
	input wire logic resetn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable
	input wire logic sig_in, // Raw pin level
	output logic level_out, // Synchronised level
	output logic fall_out, // One-cycle pulse on high to low
	output logic rise_out // One-cycle pulse on low to high
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	// ****************************************
	// Synchroniser; first flop feeds only the second
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else if (ce_in) begin
			meta_r <= sig_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	// Edge detect from registered stages gated by ce_in, so no pin glitch reaches it
	assign level_out = sync_r;
	assign fall_out = ce_in & prev_r & ~sync_r;
	assign rise_out = ce_in & ~prev_r & sync_r;
endmodule

// >>> verification/qdu_master_model.sv
// Serial bus master and load strobe driver facing the DAC block
`timescale 1ns/100ps
module qdu_master_model (
	input wire logic clk_in, // Core clock
	input wire logic sda_in, // Resolved data line level
	output logic scl_out, // Clock drive, 1 = released
	output logic sda_out, // Data drive, 1 = released
	output logic load_strobe_n_out // Load strobe to device
);
	// ****************
	// Bus tasks
	// ****************
	logic [3:0] nack_r = 4'h0; // Missed acks of last frame
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		load_strobe_n_out = 1'b1;
	end
	// Steps off the edge so the device never races the bus
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Controller picks the device and fires transfers
	task automatic strobe(input logic v);
		load_strobe_n_out = v;
	endtask
	// Start, four bytes with acks, stop; data bits move only with clock low, start and stop with clock high
	task automatic frame(input logic [31:0] b);
		sda_out = 1'b0;
		tick(8);
		for (int k = 0; k < 36; k++) begin
			scl_out = 1'b0;
			tick(3);
			sda_out = (k % 9 == 8) ? 1'b1 : b[31 - (k / 9) * 8 - k % 9];
			tick(5);
			scl_out = 1'b1;
			tick(8);
			if (k % 9 == 8) nack_r = {nack_r[2:0], sda_in};
		end
		scl_out = 1'b0;
		tick(3);
		sda_out = 1'b0;
		tick(5);
		scl_out = 1'b1;
		tick(8);
		sda_out = 1'b1; // Stop
		tick(8);
	endtask
endmodule

// >>> verification/qdu_core_assertions.sv
// Port-level checker for the quad DAC update block
`timescale 1ns/100ps
module qdu_core_assertions #(
	parameter int NV_CYCLES = 20 // Busy time in cycles
) (
	input wire logic core_clk_in, // Core clock
	input wire logic resetn_in, // Async reset, active low
	input wire logic scl_in, // Serial clock
	input wire logic load_strobe_n_in, // Load strobe
	input wire logic [47:0] nv_code_in, // Stored codes
	input wire logic nv_reload_in, // Reload pulse
	input wire logic sda_out, // Data drive value
	input wire logic sda_oe_n_out, // Data pull enable
	input wire logic nv_program_ready_n_busy_oe_n_out, // Busy pull enable
	input wire logic [47:0] dac_out, // Output registers
	input wire logic [47:0] input_reg_out // Input registers
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	// ****************
	// Properties
	// ****************
	int busy_cnt_r; // Length of the current busy run
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) busy_cnt_r <= 0;
		else if (nv_program_ready_n_busy_oe_n_out) busy_cnt_r <= 0;
		else busy_cnt_r <= busy_cnt_r + 1;
	end
	a_reset_load: assert property ($rose(resetn_in) |=>
		dac_out == $past(nv_code_in) && input_reg_out == $past(nv_code_in))
		else $error("reset load missing");
	a_reload_both: assert property (nv_reload_in |-> ##[1:4]
		(dac_out == nv_code_in && input_reg_out == nv_code_in)) else $error("reload missing");
	a_strobe_all: assert property ($fell(load_strobe_n_in) |-> ##[2:4]
		dac_out == input_reg_out) else $error("strobe did not copy");
	a_strobe_once: assert property ((!load_strobe_n_in && $stable(input_reg_out)) [*6]
		|-> $stable(dac_out)) else $error("extra transfer");
	a_held_low: assert property (!load_strobe_n_in && $past(!load_strobe_n_in, 4)
		&& $changed(input_reg_out) |-> ##[0:2] dac_out == input_reg_out)
		else $error("held strobe missed ack");
	a_ack_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("data moved with clock high");
	a_input_scl_low: assert property ($changed(input_reg_out) && $past(resetn_in, 2)
		&& !$past(nv_reload_in) && !$past(nv_reload_in, 2) |-> !scl_in)
		else $error("input written with clock high");
	a_sda_pull_only: assert property (sda_out == 1'b0) else $error("data driven high");
	a_busy_min: assert property ($fell(nv_program_ready_n_busy_oe_n_out) |=>
		!nv_program_ready_n_busy_oe_n_out [*8]) else $error("busy too short");
	a_busy_bound: assert property (busy_cnt_r <= NV_CYCLES + 1)
		else $error("busy too long");
endmodule
bind qdu_core qdu_core_assertions #(.NV_CYCLES(NV_CYCLES)) i_qdu_core_assertions (
	.core_clk_in(core_clk_in), .resetn_in(resetn_in), .scl_in(scl_in),
	.load_strobe_n_in(load_strobe_n_in), .nv_code_in(nv_code_in),
	.nv_reload_in(nv_reload_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
	.nv_program_ready_n_busy_oe_n_out(nv_program_ready_n_busy_oe_n_out),
	.dac_out(dac_out), .input_reg_out(input_reg_out));

// >>> verification/qdu_core_tb_top.sv
// Self-checking bench for the quad DAC update block
`timescale 1ns/100ps
module qdu_core_tb_top;
	// ****************
	// Clock, reset, wiring
	// ****************
	localparam int NVC = 20;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [47:0] nv_code = 48'h123456789ABC;
	logic nv_reload = 1'b0;
	logic m_scl, m_sda, strobe_n, d_sda, sda_oe_n, busy_oe_n;
	logic [47:0] dac, inreg, exp_in, exp_dac;
	int fail_count = 0;
	int num_checks = 0;
	int busy_len = 0;
	// Pull-up: any party may pull the data line low
	wire sda = m_sda & (sda_oe_n | d_sda);
	always #25 core_clk = ~core_clk;
	// Counted on the falling edge, where the pin has settled
	always @(negedge core_clk) if (!busy_oe_n) busy_len++;
	qdu_core #(.NV_CYCLES(NVC)) i_qdu_core (
		.core_clk_in(core_clk), .resetn_in(resetn), .ce_in(1'b1), .scl_in(m_scl),
		.sda_in(sda), .sda_out(d_sda), .sda_oe_n_out(sda_oe_n),
		.load_strobe_n_in(strobe_n), .nv_code_in(nv_code), .nv_reload_in(nv_reload),
		.nv_program_ready_n_busy_oe_n_out(busy_oe_n), .dac_out(dac), .input_reg_out(inreg));
	qdu_master_model i_qdu_master_model (.clk_in(core_clk), .sda_in(sda),
		.scl_out(m_scl), .sda_out(m_sda), .load_strobe_n_out(strobe_n));
	// ****************
	// Helpers
	// ****************
	task automatic tick(input int n);
		i_qdu_master_model.tick(n);
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One channel write; update bit low means update now
	task automatic wr(input logic [1:0] ch, input logic upd, input logic nv,
		input logic [11:0] code);
		i_qdu_master_model.frame({8'hC0, 3'h3, nv, 1'b1, ch, upd, 4'h0, code});
		exp_in[ch * 12 +: 12] = code;
		if (!upd || !strobe_n) exp_dac[ch * 12 +: 12] = code;
		chk({44'h0, i_qdu_master_model.nack_r}, 48'h0);
		chk(inreg, exp_in);
		chk(dac, exp_dac);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_chans();
		for (int c = 0; c < 4; c++) wr(c[1:0], 1'b0, 1'b0, 12'hA50 + c[11:0]);
		$display("test channel select done");
	endtask
	// Held back codes, one strobe fall, then strobe held low
	task automatic t_strobe();
		for (int c = 0; c < 4; c++) wr(c[1:0], 1'b1, 1'b0, 12'h3C0 + c[11:0]);
		i_qdu_master_model.strobe(1'b0);
		tick(5);
		exp_dac = exp_in;
		chk(dac, exp_dac);
		wr(2'h2, 1'b1, 1'b0, 12'hFFF);
		chk(dac, exp_dac);
		i_qdu_master_model.strobe(1'b1);
		tick(2);
		$display("test strobe done");
	endtask
	task automatic t_busy();
		chk(busy_oe_n, 1'b1);
		busy_len = 0;
		wr(2'h1, 1'b0, 1'b1, 12'h5A5);
		tick(40);
		chk(busy_len, NVC);
		chk(busy_oe_n, 1'b1);
		$display("test busy done");
	endtask
	// Foreign address: nothing acked, nothing written
	task automatic t_refuse();
		i_qdu_master_model.frame({8'hC2, 8'h68, 16'h0FFF});
		chk({44'h0, i_qdu_master_model.nack_r}, 48'hF);
		chk(inreg, exp_in);
		chk(dac, exp_dac);
		$display("test refuse done");
	endtask
	// Address write: refused after byte0 with strobe high, acked in full with it low
	task automatic t_addr();
		i_qdu_master_model.frame({8'hC0, 8'h60, 16'h0000});
		chk({44'h0, i_qdu_master_model.nack_r}, 48'h3);
		i_qdu_master_model.strobe(1'b0);
		tick(5);
		exp_dac = exp_in;
		i_qdu_master_model.frame({8'hC0, 8'h60, 16'h0000});
		chk({44'h0, i_qdu_master_model.nack_r}, 48'h0);
		chk(inreg, exp_in);
		chk(dac, exp_dac);
		i_qdu_master_model.strobe(1'b1);
		tick(2);
		$display("test address select done");
	endtask
	task automatic t_reload();
		nv_code = 48'hFEDCBA987654;
		nv_reload = 1'b1;
		tick(1);
		nv_reload = 1'b0;
		tick(4);
		chk(inreg, nv_code);
		chk(dac, nv_code);
		// General call reset: only address and byte0 acknowledged
		nv_code = 48'h0F0E0D0C0B0A;
		i_qdu_master_model.frame({8'h00, 8'h06, 16'h0000});
		chk({44'h0, i_qdu_master_model.nack_r}, 48'h3);
		chk(inreg, nv_code);
		chk(dac, nv_code);
		$display("test reload done");
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence; stored codes land in both sets at release
	initial begin
		tick(4);
		resetn = 1'b1;
		tick(2);
		exp_in = nv_code;
		exp_dac = nv_code;
		chk(inreg, exp_in);
		chk(dac, exp_dac);
		tick(4);
		t_chans();
		t_strobe();
		t_busy();
		t_refuse();
		t_addr();
		t_reload();
		finish_test();
	end
	// Hang guard
	initial begin
		#2000000;
		fail_count++;
		finish_test();
	end
endmodule
